// >>> rtl/uart_sd.sv
// uart core with serial word port, shutdown control and stop-bit framing
// How it works
// - one bit: activity in shutdown, framing error otherwise
// - rx edge in shutdown sets activity flag
// - zero at first stop bit flags error
// - next good character clears framing error
// - data read keeps flag; config write clears
// - framing error returns receiver to idle
// - shutdown after cs rise, once transmitter idle
// - shutdown clears flags, data and transmit buffer
// - rts and cts untouched by shutdown
// - exit shutdown, oscillator restarts after delay
// - readback shows shutdown only after transmit done
// - hard shutdown sets readback immediately
// - one or two stop bits by setting
// - receiver needs only one stop bit
// - transmit-empty flag high when buffer free, outside configured shutdown
// - disable qualifier: update rts only, send nothing
// - qualifier clear: update rts and transmit data
// - interrupt while mask and transmit-empty both set
// - stop setting read back; reset values zero
// - mask immediate, other config after transmission
`timescale 1ns/100ps
module uart_sd #(
	parameter int TICK_DIV = uart_sd_pkg::TICK_CYCLES,
	parameter int OSC_RESTART = uart_sd_pkg::OSC_RESTART_CYCLES
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// serial word port
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic din_in,
	output logic dout_out,
	// async serial line and handshake
	input wire logic rx_in,
	output logic tx_out,
	input wire logic cts_n_in,
	output logic rts_n_out,
	// shutdown and interrupt
	input wire logic hard_powerdown_input_n_in,
	output logic irq_n_out
);

	// ==========================================================
	// input synchronisers
	logic [4:0] meta_q;
	logic sclk_s_q, sclk_p_q, cs_s_q, cs_p_q, din_s_q, rx_s_q, rx_p_q, cts_s_q, hwn_s_q;
	always_ff @(posedge clk_in) begin
		meta_q <= {sclk_in, cs_n_in, din_in, rx_in, hard_powerdown_input_n_in};
		{sclk_s_q, cs_s_q, din_s_q, rx_s_q, hwn_s_q} <= meta_q;
		cts_s_q <= cts_n_in;
		sclk_p_q <= sclk_s_q;
		cs_p_q <= cs_s_q;
		rx_p_q <= rx_s_q;
	end
	// cts passes a single extra stage: it is only displayed, never decides anything
	logic cts_m_q;
	always_ff @(posedge clk_in) cts_m_q <= cts_s_q;

	wire sclk_rise = sclk_s_q & ~sclk_p_q;
	wire sclk_fall = ~sclk_s_q & sclk_p_q;
	wire cs_rise = cs_s_q & ~cs_p_q;
	wire cs_fall = ~cs_s_q & cs_p_q;
	wire hw_down = ~hwn_s_q;

	// ==========================================================
	// state declarations
	logic [15:0] shift_q, word_q;
	logic [4:0] cnt_q;
	logic dout_q;
	logic tm_q, rts_q, rx_activity_or_frame_error_q, r_q, tx_full_q, pend_q;
	uart_sd_pkg::cfg_t cfg_q, pend_cfg_q;
	logic [7:0] rx_data_q, tx_buf_q;
	logic tx_xbit_q;
	logic osc_ok_q;
	logic [31:0] osc_cnt_q;
	logic [15:0] div_q;
	logic sd_rb_q, irq_n_q, tx_q, rts_n_q;

	// ==========================================================
	// word decode
	wire word_done = cs_rise & (cnt_q == 5'(uart_sd_pkg::WORD_BITS));
	wire [1:0] cmd = {shift_q[uart_sd_pkg::CMD_HI_POS], shift_q[uart_sd_pkg::CMD_LO_POS]};
	wire cfg_wr = word_done & (cmd == uart_sd_pkg::CMD_WR_CFG);
	wire dat_wr = word_done & (cmd == uart_sd_pkg::CMD_WR_DATA);
	wire te_bit = shift_q[uart_sd_pkg::TE_POS];
	wire data_xfer_end = sclk_fall & (cnt_q == 5'(uart_sd_pkg::WORD_BITS)) & ~shift_q[14];
	wire [1:0] early_cmd = {shift_q[0], din_s_q};
	wire t_flag = ~tx_full_q & ~cfg_q.hard_powerdown_input;
	wire sd_now = cfg_q.hard_powerdown_input | hw_down;
	wire [13:0] cfg_rb = {1'b0, sd_rb_q, tm_q, 3'h0, 1'b0, cfg_q.st, 6'h0};
	wire [13:0] dat_rb = {3'h0, rx_activity_or_frame_error_q, ~cts_m_q, 1'b0, rx_data_q};

	// ==========================================================
	// serial word port
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			shift_q <= 16'h0000;
			word_q <= 16'h0000;
			cnt_q <= 5'h00;
			dout_q <= 1'b0;
		end else if (cs_fall) begin
			cnt_q <= 5'h00;
			word_q <= {r_q, t_flag, 14'h0000};
			dout_q <= r_q;
		end else if (!cs_s_q && sclk_rise && cnt_q != 5'h10) begin
			shift_q <= {shift_q[14:0], din_s_q};
			cnt_q <= cnt_q + 5'h01;
			if (cnt_q == 5'h01)
				word_q[13:0] <= (early_cmd == uart_sd_pkg::CMD_RD_CFG) ? cfg_rb :
					(early_cmd[0] ? 14'h0000 : dat_rb);
		end else if (!cs_s_q && sclk_fall && cnt_q != 5'h00 && cnt_q != 5'h10) begin
			dout_q <= word_q[4'(15 - cnt_q[3:0])];
		end
	end

	// ==========================================================
	// configuration, mask and shutdown sequencing
	wire tx_busy;
	wire apply_cfg = pend_q & ~tx_busy & ~tx_full_q;
	wire enter_sd = apply_cfg & pend_cfg_q.hard_powerdown_input & ~cfg_q.hard_powerdown_input;
	wire exit_sd = apply_cfg & ~pend_cfg_q.hard_powerdown_input & cfg_q.hard_powerdown_input;
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			tm_q <= uart_sd_pkg::TM_RESET;
			cfg_q <= '{hard_powerdown_input: uart_sd_pkg::HARD_POWERDOWN_INPUT_RESET, st: uart_sd_pkg::ST_RESET};
			pend_cfg_q <= '{hard_powerdown_input: uart_sd_pkg::HARD_POWERDOWN_INPUT_RESET, st: uart_sd_pkg::ST_RESET};
			pend_q <= 1'b0;
			rts_q <= uart_sd_pkg::RTS_RESET;
		end else begin
			if (cfg_wr) begin
				tm_q <= shift_q[uart_sd_pkg::TM_POS];
				pend_cfg_q <= '{hard_powerdown_input: shift_q[uart_sd_pkg::HARD_POWERDOWN_INPUT_POS], st: shift_q[uart_sd_pkg::ST_POS]};
				pend_q <= 1'b1;
			end else if (apply_cfg) begin
				cfg_q <= pend_cfg_q;
				pend_q <= 1'b0;
			end
			if (dat_wr)
				rts_q <= shift_q[uart_sd_pkg::RTS_POS];
		end
	end

	// oscillator model: stops in shutdown, restarts after a delay
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			osc_ok_q <= 1'b1;
			osc_cnt_q <= 32'h0;
		end else if (enter_sd || hw_down) begin
			osc_ok_q <= 1'b0;
			osc_cnt_q <= 32'h0;
		end else if (!osc_ok_q && !cfg_q.hard_powerdown_input) begin
			osc_cnt_q <= osc_cnt_q + 32'h1;
			if (osc_cnt_q == 32'(OSC_RESTART - 1))
				osc_ok_q <= 1'b1;
		end
	end
	wire unused_exit = exit_sd;

	// 16x baud tick
	wire tick = osc_ok_q & (div_q == 16'(TICK_DIV - 1));
	always_ff @(posedge clk_in) begin
		if (reset_in || !osc_ok_q || div_q == 16'(TICK_DIV - 1))
			div_q <= 16'h0000;
		else
			div_q <= div_q + 16'h0001;
	end

	// ==========================================================
	// transmitter
	uart_sd_pkg::tx_state_t tx_state_q;
	logic [3:0] tx_sub_q;
	logic [2:0] tx_bit_q;
	logic [7:0] tx_sh_q;
	logic tx_stops_q;
	assign tx_busy = (tx_state_q != uart_sd_pkg::TX_IDLE);
	wire tx_load = dat_wr & ~te_bit & ~tx_full_q & ~sd_now;
	wire bit_end = tick & (tx_sub_q == 4'hf);
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			tx_state_q <= uart_sd_pkg::TX_IDLE;
			tx_sub_q <= 4'h0;
			tx_bit_q <= 3'h0;
			tx_sh_q <= 8'h00;
			tx_stops_q <= 1'b0;
			tx_q <= 1'b1;
			tx_full_q <= 1'b0;
			tx_buf_q <= 8'h00;
			tx_xbit_q <= 1'b0;
		end else begin
			if (tick)
				tx_sub_q <= tx_sub_q + 4'h1;
			if (enter_sd) begin
				tx_full_q <= 1'b0;
				tx_buf_q <= 8'h00;
				tx_xbit_q <= 1'b0;
			end else if (tx_load) begin
				tx_full_q <= 1'b1;
				tx_buf_q <= shift_q[7:0];
				tx_xbit_q <= shift_q[uart_sd_pkg::XBIT_POS];
			end
			case (tx_state_q)
				uart_sd_pkg::TX_IDLE: begin
					if (tx_full_q && tick && !pend_q) begin
						tx_state_q <= uart_sd_pkg::TX_START;
						tx_sh_q <= tx_buf_q;
						tx_full_q <= 1'b0;
						tx_sub_q <= 4'h0;
						tx_q <= 1'b0;
					end
				end
				uart_sd_pkg::TX_START: begin
					if (bit_end) begin
						tx_state_q <= uart_sd_pkg::TX_DATA;
						tx_q <= tx_sh_q[0];
						tx_bit_q <= 3'h0;
					end
				end
				uart_sd_pkg::TX_DATA: begin
					if (bit_end) begin
						tx_sh_q <= {1'b0, tx_sh_q[7:1]};
						tx_bit_q <= tx_bit_q + 3'h1;
						tx_q <= (tx_bit_q == 3'h7) ? 1'b1 : tx_sh_q[1];
						if (tx_bit_q == 3'h7) begin
							tx_state_q <= uart_sd_pkg::TX_STOP;
							tx_stops_q <= cfg_q.st;
						end
					end
				end
				default: begin
					if (bit_end) begin
						if (tx_stops_q)
							tx_stops_q <= 1'b0;
						else
							tx_state_q <= uart_sd_pkg::TX_IDLE;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// receiver and activity/framing flag
	uart_sd_pkg::rx_state_t rx_state_q;
	logic [3:0] rx_sub_q;
	logic [2:0] rx_bit_q;
	logic [7:0] rx_sh_q;
	wire rx_mid = tick & (rx_sub_q == 4'h7);
	wire frame_bad = (rx_state_q == uart_sd_pkg::RX_STOP) & rx_mid & ~rx_s_q;
	wire frame_ok = (rx_state_q == uart_sd_pkg::RX_STOP) & rx_mid & rx_s_q;
	wire rx_activity = cfg_q.hard_powerdown_input & (rx_s_q != rx_p_q);
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			rx_state_q <= uart_sd_pkg::RX_IDLE;
			rx_sub_q <= 4'h0;
			rx_bit_q <= 3'h0;
			rx_sh_q <= 8'h00;
		end else begin
			if (tick)
				rx_sub_q <= rx_sub_q + 4'h1;
			case (rx_state_q)
				uart_sd_pkg::RX_IDLE: begin
					if (osc_ok_q && !rx_s_q && rx_p_q) begin
						rx_state_q <= uart_sd_pkg::RX_START;
						rx_sub_q <= 4'h0;
					end
				end
				uart_sd_pkg::RX_START: begin
					if (rx_mid)
						rx_state_q <= rx_s_q ? uart_sd_pkg::RX_IDLE : uart_sd_pkg::RX_DATA;
					rx_bit_q <= 3'h0;
				end
				uart_sd_pkg::RX_DATA: begin
					if (rx_mid) begin
						rx_sh_q <= {rx_s_q, rx_sh_q[7:1]};
						rx_bit_q <= rx_bit_q + 3'h1;
						if (rx_bit_q == 3'h7)
							rx_state_q <= uart_sd_pkg::RX_STOP;
					end
				end
				default: begin
					if (rx_mid)
						rx_state_q <= uart_sd_pkg::RX_IDLE;
				end
			endcase
			if (!osc_ok_q)
				rx_state_q <= uart_sd_pkg::RX_IDLE;
		end
	end

	// flags: setting events win over clears
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			rx_activity_or_frame_error_q <= uart_sd_pkg::FLAG_RESET;
			r_q <= uart_sd_pkg::FLAG_RESET;
			rx_data_q <= 8'h00;
		end else begin
			if (frame_bad || rx_activity)
				rx_activity_or_frame_error_q <= 1'b1;
			else if (frame_ok || cfg_wr || enter_sd)
				rx_activity_or_frame_error_q <= 1'b0;
			if (frame_ok) begin
				r_q <= 1'b1;
				rx_data_q <= rx_sh_q;
			end else if (data_xfer_end || cfg_wr || enter_sd) begin
				r_q <= 1'b0;
				if (enter_sd)
					rx_data_q <= 8'h00;
			end
		end
	end

	// ==========================================================
	// registered outputs
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			sd_rb_q <= 1'b0;
			irq_n_q <= 1'b1;
			rts_n_q <= 1'b1;
		end else begin
			sd_rb_q <= sd_now;
			irq_n_q <= ~(tm_q & t_flag);
			rts_n_q <= ~rts_q;
		end
	end
	assign dout_out = dout_q;
	assign tx_out = tx_q;
	assign rts_n_out = rts_n_q;
	assign irq_n_out = irq_n_q;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	property p_irq; tm_q && t_flag |=> !irq_n_out; endproperty
	a_irq: assert property (p_irq) else $error("irq not asserted");
	property p_act; rx_activity |=> rx_activity_or_frame_error_q; endproperty
	a_act: assert property (p_act) else $error("activity not flagged");
	property p_fe; frame_bad |=> rx_activity_or_frame_error_q && rx_state_q == uart_sd_pkg::RX_IDLE; endproperty
	a_fe: assert property (p_fe) else $error("framing error mishandled");
	property p_cfgclr; cfg_wr && !frame_bad && !rx_activity |=> !rx_activity_or_frame_error_q; endproperty
	a_cfgclr: assert property (p_cfgclr) else $error("config write kept flag");
	property p_hw; hw_down |=> sd_rb_q; endproperty
	a_hw: assert property (p_hw) else $error("hard shutdown not shown");
	property p_sdrb; cfg_q.hard_powerdown_input |-> !tx_busy; endproperty
	a_sdrb: assert property (p_sdrb) else $error("shutdown while sending");
	property p_stop; $rose(tx_state_q == uart_sd_pkg::TX_STOP) |-> tx_stops_q == cfg_q.st; endproperty
	a_stop: assert property (p_stop) else $error("wrong stop count");
	property p_te; dat_wr && te_bit && !tx_full_q |=> !tx_full_q; endproperty
	a_te: assert property (p_te) else $error("sent with transmit disabled");
	property p_tm; cfg_wr |=> tm_q == $past(shift_q[uart_sd_pkg::TM_POS]); endproperty
	a_tm: assert property (p_tm) else $error("mask not immediate");

endmodule // uart_sd

// >>> rtl/uart_sd_pkg.sv
// shared constants and types for the uart status, shutdown and framing block
package uart_sd_pkg;

	// ==========================================================
	// clock and timing
	localparam int CLK_HZ = 25000000;
	localparam int BAUD_HZ = 9600;
	localparam int OVERSAMPLE = 16;
	localparam int TICK_CYCLES = CLK_HZ / (BAUD_HZ * OVERSAMPLE);
	localparam int OSC_RESTART_MS = 50;
	localparam int OSC_RESTART_CYCLES = OSC_RESTART_MS * (CLK_HZ / 1000);

	// ==========================================================
	// serial word layout
	localparam int WORD_BITS = 16;
	localparam int CMD_HI_POS = 15;
	localparam int CMD_LO_POS = 14;
	localparam int HARD_POWERDOWN_INPUT_POS = 12;
	localparam int TM_POS = 11;
	localparam int ST_POS = 6;
	localparam int TE_POS = 10;
	localparam int RTS_POS = 9;
	localparam int XBIT_POS = 8;
	localparam logic [1:0] CMD_WR_CFG = 2'h3;
	localparam logic [1:0] CMD_RD_CFG = 2'h1;
	localparam logic [1:0] CMD_WR_DATA = 2'h2;
	localparam logic [1:0] CMD_RD_DATA = 2'h0;

	// ==========================================================
	// reset values
	localparam logic TM_RESET = 1'b0;
	localparam logic ST_RESET = 1'b0;
	localparam logic HARD_POWERDOWN_INPUT_RESET = 1'b0;
	localparam logic FLAG_RESET = 1'b0;
	localparam logic RTS_RESET = 1'b0;

	// ==========================================================
	// types
	typedef struct packed {
		logic hard_powerdown_input;
		logic st;
	} cfg_t;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_START = 2'b01,
		TX_DATA = 2'b10,
		TX_STOP = 2'b11
	} tx_state_t;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b10,
		RX_STOP = 2'b11
	} rx_state_t;

endpackage

// >>> dv/spi_host_model.sv
// host model that drives the serial word port as bus master
`timescale 1ns/100ps
module spi_host_model (
	// clock
	input wire logic clk_in,
	// serial word port
	output logic sclk_out,
	output logic cs_n_out,
	output logic din_out,
	input wire logic dout_in
);
	// ==========================================================
	// idle levels: clock stands still low between words
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		din_out = 1'b0;
	end

	// ==========================================================
	// one 16-bit word, msb first, sclk period 8 clocks (320 ns)
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		@(posedge clk_in);
		cs_n_out <= 1'b0;
		repeat (4) @(posedge clk_in);
		for (int i = 15; i >= 0; i--) begin
			din_out <= w[i];
			repeat (4) @(posedge clk_in);
			r[i] = dout_in;
			sclk_out <= 1'b1;
			repeat (4) @(posedge clk_in);
			sclk_out <= 1'b0;
		end
		repeat (4) @(posedge clk_in);
		cs_n_out <= 1'b1;
		// released data line no longer shows the last bit
		din_out <= ~w[0];
		repeat (8) @(posedge clk_in);
	endtask
endmodule // spi_host_model

// >>> dv/tb_uart_sd.sv
// self-checking bench for the uart status, shutdown and framing block
`timescale 1ns/100ps
module tb_uart_sd;
	// ==========================================================
	// signals
	logic clk_in, reset_in, sclk, cs_n, din, dout, rx_in, tx, cts_n, rts_n, hard_n, irq_n;
	logic [15:0] rd;
	int n_errors = 0;
	int cmp_count = 0;
	localparam int BIT_CLK = 32;

	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end

	uart_sd #(.TICK_DIV(2), .OSC_RESTART(20)) uut (.clk_in(clk_in), .reset_in(reset_in),
		.sclk_in(sclk), .cs_n_in(cs_n), .din_in(din), .dout_out(dout), .rx_in(rx_in),
		.tx_out(tx), .cts_n_in(cts_n), .rts_n_out(rts_n),
		.hard_powerdown_input_n_in(hard_n), .irq_n_out(irq_n));
	spi_host_model host (.clk_in(clk_in), .sclk_out(sclk), .cs_n_out(cs_n), .din_out(din),
		.dout_in(dout));

	// ==========================================================
	// shared helpers
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// one 8n1 character on the receive line, stop level chosen
	task automatic rx_frame(input logic [7:0] b, input logic stop);
		rx_in <= 1'b0;
		repeat (BIT_CLK) @(posedge clk_in);
		for (int i = 0; i < 8; i++) begin
			rx_in <= b[i];
			repeat (BIT_CLK) @(posedge clk_in);
		end
		rx_in <= stop;
		repeat (20) @(posedge clk_in);
		rx_in <= 1'b1;
		repeat (60) @(posedge clk_in);
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset();
		host.xfer(16'h4000, rd);
		check("cfg reset", 16'h4000, rd);
		check("pins reset", 3'h7, {irq_n, tx, rts_n});
		$display("test reset done");
	endtask

	task automatic t_mask();
		host.xfer(16'hc800, rd);
		check("irq on", 0, irq_n);
		host.xfer(16'h4000, rd);
		check("tm back", 16'h4800, rd);
		host.xfer(16'hc000, rd);
		check("irq off", 1, irq_n);
		$display("test mask done");
	endtask

	task automatic t_tx(input logic st);
		int k;
		logic [7:0] b;
		k = 0;
		b = 8'ha5;
		host.xfer({9'h180, st, 6'h00}, rd);
		host.xfer(16'h4000, rd);
		check("stop cfg", {9'h080, st, 6'h00}, rd);
		fork
			begin
				host.xfer(16'h82a5, rd);
				host.xfer(16'h823c, rd);
			end
			begin
				while (tx !== 1'b0 && k < 400) begin
					@(posedge clk_in);
					k++;
				end
				repeat (16) @(posedge clk_in);
				check("start", 0, tx);
				for (int i = 0; i < 8; i++) begin
					repeat (BIT_CLK) @(posedge clk_in);
					check("tx bit", b[i], tx);
				end
				repeat (BIT_CLK) @(posedge clk_in);
				check("stop", 1, tx);
				k = 16 + 9 * BIT_CLK;
				while (tx === 1'b1 && k < 600) begin
					@(posedge clk_in);
					k++;
				end
				check("gap", 1, k >= 320 + 32 * st && k <= 324 + 32 * st);
			end
		join
		check("rts on", 0, rts_n);
		repeat (400) @(posedge clk_in);
		$display("test tx done");
	endtask

	task automatic t_txdis();
		int lows;
		lows = 0;
		host.xfer(16'h8455, rd);
		check("rts off", 1, rts_n);
		repeat (200) begin
			@(posedge clk_in);
			if (tx !== 1'b1) lows++;
		end
		check("no send", 0, lows[15:0]);
		$display("test disable done");
	endtask

	task automatic t_rx();
		rx_frame(8'h96, 1'b0);
		host.xfer(16'h0000, rd);
		check("fe set", 1, rd[10]);
		host.xfer(16'h0000, rd);
		check("fe kept", 1, rd[10]);
		rx_frame(8'h3c, 1'b1);
		host.xfer(16'h0000, rd);
		check("fe clr", 0, rd[10]);
		check("rx byte", 9'h13c, {rd[15], rd[7:0]});
		rx_frame(8'h11, 1'b0);
		host.xfer(16'hc040, rd);
		host.xfer(16'h0000, rd);
		check("fe cfg", 0, rd[10]);
		$display("test rx done");
	endtask

	task automatic t_hard_powerdown_input();
		hard_n <= 1'b0;
		host.xfer(16'h4000, rd);
		check("hard sd", 1, rd[12]);
		hard_n <= 1'b1;
		repeat (40) @(posedge clk_in);
		host.xfer(16'hd000, rd);
		host.xfer(16'h4000, rd);
		check("soft sd", 16'h1000, rd);
		rx_in <= 1'b0;
		repeat (8) @(posedge clk_in);
		rx_in <= 1'b1;
		host.xfer(16'h0000, rd);
		check("activity", 16'h0600, rd);
		host.xfer(16'h8600, rd);
		check("rts sd", 0, rts_n);
		host.xfer(16'hc000, rd);
		repeat (40) @(posedge clk_in);
		check("rts kept", 0, rts_n);
		host.xfer(16'h4000, rd);
		check("wake cfg", 16'h4000, rd);
		$display("test shutdown done");
	endtask

	// ==========================================================
	// main sequence and watchdog
	initial begin
		reset_in = 1'b1;
		rx_in = 1'b1;
		cts_n = 1'b0;
		hard_n = 1'b1;
		repeat (2) @(posedge clk_in);
		reset_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		t_reset();
		t_mask();
		t_tx(1'b0);
		t_tx(1'b1);
		t_txdis();
		t_rx();
		t_hard_powerdown_input();
		conclude();
	end

	initial begin
		repeat (40000) @(posedge clk_in);
		n_errors++;
		conclude();
	end
endmodule // tb_uart_sd
